// File: jcl_consts.svh
`ifndef JCL_CONSTS_SVH
`define JCL_CONSTS_SVH

// instruction register
`define JCL_IR_W 4
`define JCL_IR_CAPTURE 4'h1
`define JCL_IR_CFG_WRITE 4'h2
`define JCL_IR_CFG_INIT 4'h3
`define JCL_IR_ICB_WRITE 4'h4
`define JCL_IR_ICB_ERASE 4'h5
`define JCL_IR_WDOG_OFF 4'h6
`define JCL_IR_BYPASS 4'hf

// init_config_bits layout and built-in default
`define JCL_ICB_W 8
`define JCL_ICB_WDOG_BIT 0
`define JCL_ICB_PULLUP_BIT 1
`define JCL_ICB_DEFAULT 8'h03
`define JCL_ICB_ERASED 8'h00

// config_ram shape
`define JCL_CFG_WORD_W 8
`define JCL_CFG_DEPTH 16

// timing
`define JCL_INIT_CYCLES 64
`define JCL_MCLK_MHZ 10
`define JCL_WDOG_US 1000

`endif

// File: jcl_loader.sv
// Function
// R1: in bypass, tdi reaches tdo through one flop, one tck later.
// R2: programmer bypasses all other chain devices before configuring one.
// R3: programmer shifts the whole image in on tdi before initialization.
// R4: after loading, tck cycles drive the initialization sequence.
// R5: config_done_flag low on failure, high on success; programmer reads it.
// R6: jtag image writes config_ram only, never init_config_bits.
// R7: init_config_bits change only during flash image programming.
// R8: init_config_bits persist over reconfiguration until flash erase.
// R9: jtag configuration applies the stored init_config_bits.
// R10: with nothing stored, built-in default init_config_bits apply.
// R11: programmer clears watchdog enable on devices with no stored bits.
// R12: enabled watchdog timeout starts a reconfiguration.
// R13: initialization starts only once config_done_flag is high.
// R14: programmer holds jtag pins static during initialization.
// R15: standard tap machine; sample on rising tck, drive tdo on falling.
`timescale 1ns/1ns
`include "jcl_consts.svh"
module jcl_loader #(
  parameter int CFG_W = `JCL_CFG_WORD_W,
  parameter int CFG_DEPTH = `JCL_CFG_DEPTH,
  parameter int INIT_CYCLES = `JCL_INIT_CYCLES,
  parameter int WDOG_CYCLES = `JCL_WDOG_US * `JCL_MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tck,
  input jcl_pkg::jcl_jtag_t jtag_in,
  output logic tdo,
  output logic tdo_oe,
  input wire logic config_done_flag_in,
  output jcl_pkg::jcl_odpin_t config_done_flag_pin,
  input wire logic wdog_kick,
  output logic [CFG_DEPTH*CFG_W-1:0] config_ram,
  output logic [`JCL_ICB_W-1:0] icb_applied,
  output logic init_done,
  output logic user_mode,
  output logic reconfig_req
);
  import jcl_pkg::*;

  localparam int AW = $clog2(CFG_DEPTH);
  localparam int CW = $clog2(INIT_CYCLES + 1);
  localparam int WW = $clog2(WDOG_CYCLES + 1);
  localparam logic [AW:0] FULL = (AW + 1)'(CFG_DEPTH);
  localparam logic [AW:0] LAST = (AW + 1)'(CFG_DEPTH - 1);
  localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYCLES - 1);
  localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_CYCLES - 1);
  localparam logic [`JCL_ICB_W-1:0] WDOG_MASK = `JCL_ICB_W'(1) << `JCL_ICB_WDOG_BIT;

  // ---------------- tck domain ----------------
  jcl_tap_t st_r, st_nxt;
  logic [`JCL_IR_W-1:0] ir_sh_r, ir_r;
  logic byp_r;
  logic [CFG_W-1:0] cfg_sh_r;
  logic [`JCL_ICB_W-1:0] icb_sh_r, icb_r, icb_eff;
  logic icb_valid_r, wdog_off_r;
  logic [AW:0] wcnt_r;
  logic cfg_ok_r;
  logic [CW-1:0] init_cnt_r;
  logic cd_sync, rcfg_sync, rcfg_seen_r;

  wire tms = jtag_in.tms;
  wire tdi = jtag_in.tdi;
  wire cap_ir = st_r == S_CAP_IR;
  wire sh_ir = st_r == S_SH_IR;
  wire upd_ir = st_r == S_UPD_IR;
  wire cap_dr = st_r == S_CAP_DR;
  wire sh_dr = st_r == S_SH_DR;
  wire upd_dr = st_r == S_UPD_DR;
  wire sel_cfg = ir_r == `JCL_IR_CFG_WRITE;
  wire sel_icb = ir_r == `JCL_IR_ICB_WRITE;
  wire new_image = upd_ir && ir_sh_r == `JCL_IR_CFG_WRITE;
  wire wcnt_full = wcnt_r == FULL;
  wire config_ram_we = upd_dr && sel_cfg && !wcnt_full;
  wire icb_we = upd_dr && sel_icb;
  wire icb_erase = upd_dr && ir_r == `JCL_IR_ICB_ERASE;
  wire wdog_off_we = upd_dr && ir_r == `JCL_IR_WDOG_OFF;
  wire rcfg_evt = rcfg_sync ^ rcfg_seen_r;
  wire init_go = ir_r == `JCL_IR_CFG_INIT && st_r == S_RTI && cfg_ok_r && cd_sync && !init_done;
  wire tdo_nxt = sh_ir ? ir_sh_r[0] : sel_cfg ? cfg_sh_r[0] : sel_icb ? icb_sh_r[0] : byp_r;

  always_comb begin // [R15]
    st_nxt = st_r;
    unique case (st_r)
      S_TLR: st_nxt = tms ? S_TLR : S_RTI;
      S_RTI: st_nxt = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: st_nxt = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_nxt = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: st_nxt = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_nxt = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: st_nxt = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: st_nxt = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: st_nxt = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: st_nxt = tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: st_nxt = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: st_nxt = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_nxt = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: st_nxt = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: st_nxt = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: st_nxt = tms ? S_SEL_DR : S_RTI;
    endcase
  end

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= S_TLR;
    end else begin
      st_r <= st_nxt; // [R15]
    end
  end

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      ir_sh_r <= `JCL_IR_CAPTURE;
      ir_r <= `JCL_IR_BYPASS;
    end else if (st_r == S_TLR) begin
      ir_r <= `JCL_IR_BYPASS;
    end else if (cap_ir) begin
      ir_sh_r <= `JCL_IR_CAPTURE;
    end else if (sh_ir) begin
      ir_sh_r <= {tdi, ir_sh_r[`JCL_IR_W-1:1]};
    end else if (upd_ir) begin
      ir_r <= ir_sh_r;
    end
  end

  // single-bit path keeps a chain of bypassed parts one tck per device
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      byp_r <= 1'b0;
    end else if (cap_dr) begin
      byp_r <= 1'b0;
    end else if (sh_dr) begin
      byp_r <= tdi; // [R1]
    end
  end

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_sh_r <= '0;
      icb_sh_r <= '0;
    end else if (sh_dr) begin
      cfg_sh_r <= {tdi, cfg_sh_r[CFG_W-1:1]}; // [R3]
      icb_sh_r <= {tdi, icb_sh_r[`JCL_ICB_W-1:1]};
    end
  end

  // falling edge gives the next device a full half period of setup
  always_ff @(negedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= tdo_nxt; // [R15] [R1]
      tdo_oe <= sh_ir || sh_dr;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_DEPTH; gi++) begin : g_config_ram
      wire hit = config_ram_we && wcnt_r[AW-1:0] == AW'(gi);
      always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
          config_ram[gi*CFG_W +: CFG_W] <= '0;
        end else if (hit) begin
          config_ram[gi*CFG_W +: CFG_W] <= cfg_sh_r; // [R6]
        end
      end
    end
  endgenerate

  // image is good only at exactly CFG_DEPTH words; extras mark it bad
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      wcnt_r <= '0;
      cfg_ok_r <= 1'b0;
    end else if (rcfg_evt || new_image) begin
      wcnt_r <= '0;
      cfg_ok_r <= 1'b0;
    end else if (upd_dr && sel_cfg) begin
      wcnt_r <= wcnt_full ? wcnt_r : wcnt_r + 1'b1;
      cfg_ok_r <= !wcnt_full && wcnt_r == LAST; // [R5]
    end
  end

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      init_cnt_r <= '0;
      init_done <= 1'b0;
    end else if (rcfg_evt || new_image) begin
      init_cnt_r <= '0;
      init_done <= 1'b0;
    end else if (init_go) begin
      init_cnt_r <= init_cnt_r + 1'b1; // [R4] [R13]
      init_done <= init_cnt_r == INIT_LAST;
    end
  end

  // flash-side bits: only the flash image instruction or erase touch them
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      icb_r <= `JCL_ICB_ERASED;
      icb_valid_r <= 1'b0;
    end else if (icb_we) begin
      icb_r <= icb_sh_r; // [R7] [R8]
      icb_valid_r <= 1'b1;
    end else if (icb_erase) begin
      icb_r <= `JCL_ICB_ERASED;
      icb_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      wdog_off_r <= 1'b0;
    end else if (icb_we) begin
      wdog_off_r <= 1'b0;
    end else if (wdog_off_we) begin
      wdog_off_r <= 1'b1; // [R11]
    end
  end

  assign icb_eff = (icb_valid_r ? icb_r : `JCL_ICB_DEFAULT) & ~(wdog_off_r ? WDOG_MASK : '0); // [R9] [R10]

  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      icb_applied <= `JCL_ICB_DEFAULT;
      rcfg_seen_r <= 1'b0;
    end else begin
      icb_applied <= icb_eff;
      rcfg_seen_r <= rcfg_sync;
    end
  end

  // ---------------- mclk domain (u_sync_link runs on tck) ----------------
  logic ok_sync, init_sync, wd_bit_sync;
  logic [WW-1:0] wd_cnt_r;
  logic rcfg_tgl_r;

  wire wd_en = init_sync && wd_bit_sync;
  wire wd_hit = wd_en && !wdog_kick && wd_cnt_r == WDOG_LAST;

  jcl_sync #(.W(2)) u_sync_link (
    .clk(tck),
    .rst(sys_rst),
    .d({config_done_flag_in, rcfg_tgl_r}),
    .q({cd_sync, rcfg_sync})
  );

  jcl_sync #(.W(3)) u_sync_main (
    .clk(mclk),
    .rst(sys_rst),
    .d({cfg_ok_r, init_done, icb_applied[`JCL_ICB_WDOG_BIT]}),
    .q({ok_sync, init_sync, wd_bit_sync})
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_r <= '0;
    end else if (!wd_en || wdog_kick || wd_hit) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reconfig_req <= 1'b0;
      rcfg_tgl_r <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      reconfig_req <= wd_hit; // [R12]
      rcfg_tgl_r <= rcfg_tgl_r ^ wd_hit;
      user_mode <= init_sync;
    end
  end

  // open drain: pull low until the image checks out, then release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      config_done_flag_pin <= '{o: 1'b0, oe: 1'b1};
    end else begin
      config_done_flag_pin <= '{o: 1'b0, oe: !ok_sync}; // [R5]
    end
  end

  // ---------------- checks ----------------
  a_bypass_one_bit: assert property (@(posedge tck) disable iff (sys_rst) // [R1]
    (sh_dr && ir_r == `JCL_IR_BYPASS) |=> byp_r == $past(tdi))
    else $error("bypass flop did not take tdi");

  a_tap_tms_reset: assert property (@(posedge tck) disable iff (sys_rst) // [R15]
    (tms [*5]) |=> st_r == S_TLR)
    else $error("five tms highs did not reach reset");

  a_init_after_done: assert property (@(posedge tck) disable iff (sys_rst) // [R13]
    $rose(init_cnt_r[0]) |-> $past(cd_sync) && $past(cfg_ok_r))
    else $error("init ran without config done");

  a_init_length: assert property (@(posedge tck) disable iff (sys_rst) // [R4]
    $rose(init_done) |-> $past(init_cnt_r) == INIT_LAST)
    else $error("init length wrong");

  a_icb_flash_only: assert property (@(posedge tck) disable iff (sys_rst) // [R6] [R7] [R8]
    $changed(icb_r) |-> $past(ir_r) == `JCL_IR_ICB_WRITE || $past(ir_r) == `JCL_IR_ICB_ERASE)
    else $error("init bits changed outside flash programming");

  a_config_ram_write_gate: assert property (@(posedge tck) disable iff (sys_rst) // [R6]
    $changed(config_ram) |-> $past(ir_r) == `JCL_IR_CFG_WRITE && $past(upd_dr))
    else $error("config ram written outside image load");

  a_icb_stored_used: assert property (@(posedge tck) disable iff (sys_rst) // [R9]
    (icb_valid_r && !wdog_off_r) |=> icb_applied == $past(icb_r))
    else $error("stored init bits not applied");

  a_icb_default_used: assert property (@(posedge tck) disable iff (sys_rst) // [R10]
    (!icb_valid_r && !wdog_off_r) |=> icb_applied == `JCL_ICB_DEFAULT)
    else $error("default init bits not applied");

  a_wdog_reconfig: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
    wd_hit |=> reconfig_req ##1 !reconfig_req)
    else $error("watchdog timeout gave no reconfig pulse");

  a_done_pulls_low: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
    !ok_sync |=> config_done_flag_pin.oe && !config_done_flag_pin.o)
    else $error("config done not driven low on failure");

endmodule // jcl_loader

// File: jcl_pkg.sv
package jcl_pkg;

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jcl_tap_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } jcl_jtag_t;

  typedef struct packed {
    logic o;
    logic oe;
  } jcl_odpin_t;

endpackage

// File: jcl_prog_model.sv
`timescale 1ns/1ns
module jcl_prog_model (
  output logic tck,
  output jcl_pkg::jcl_jtag_t jtag
);
  import jcl_pkg::*;
  // tck rests high between frames; pins move 1 ns after each rising tck
  initial begin
    tck = 1'b1;
    jtag = '{tms: 1'b1, tdi: 1'b0};
  end
  task automatic step(input logic m, input logic d);
    #1 jtag = '{tms: m, tdi: d};
    #5 tck = 1'b0;
    #6 tck = 1'b1;
  endtask
  task automatic tap_reset();
    repeat (5) step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  // parking a chain member is just the bypass code through shift_ir
  task automatic shift_ir(input logic [3:0] code);
    for (int i = 0; i < 4; i++) step(i < 2, ~jtag.tdi);
    for (int i = 0; i < 4; i++) step(i == 3, code[i]);
    step(1'b1, ~jtag.tdi);
    step(1'b0, ~jtag.tdi);
  endtask
  // whole word shifted in lsb first before any init
  task automatic shift_dr(input logic [7:0] d);
    step(1'b1, ~jtag.tdi);
    step(1'b0, ~jtag.tdi);
    step(1'b0, ~jtag.tdi);
    for (int i = 0; i < 8; i++) step(i == 7, d[i]);
    step(1'b1, ~jtag.tdi);
    step(1'b0, ~jtag.tdi);
  endtask
  // tck keeps running in idle, tms and tdi held still
  task automatic idle(input int n);
    repeat (n) step(1'b0, jtag.tdi);
  endtask
endmodule // jcl_prog_model

// File: jcl_sync.sv
`timescale 1ns/1ns
module jcl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // meta_r feeds q only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // jcl_sync

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import jcl_pkg::*;
  logic mclk, sys_rst, wdog_kick, tck, tdo, tdo_oe, init_done, user_mode, reconfig_req;
  jcl_jtag_t jtag_in;
  jcl_odpin_t config_done_flag_pin;
  logic [127:0] config_ram;
  logic [127:0] img;
  logic [7:0] icb_applied;
  logic [7:0] b;
  logic exp_q[$];
  int err_count, n_tests, seed, n_rcfg;
  logic kick_on;
  int kick_gap;
  // open-drain flag with a pull-up
  wire config_done_flag_in = config_done_flag_pin.oe ? config_done_flag_pin.o : 1'b1;
  jcl_loader #(.INIT_CYCLES(8), .WDOG_CYCLES(20)) DUT (.mclk(mclk), .sys_rst(sys_rst), .tck(tck),
    .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe), .config_done_flag_in(config_done_flag_in),
    .config_done_flag_pin(config_done_flag_pin), .wdog_kick(wdog_kick), .config_ram(config_ram),
    .icb_applied(icb_applied), .init_done(init_done), .user_mode(user_mode), .reconfig_req(reconfig_req));
  jcl_prog_model prog (.tck(tck), .jtag(jtag_in));
  always #50 mclk = ~mclk;
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // tdo is settled since the falling edge, so read it at the rising one
  always @(posedge tck) begin : tdo_watch
    logic e;
    if (tdo_oe === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("tdo", e, tdo);
    end
  end
  always @(posedge mclk) begin
    if (reconfig_req === 1'b1) n_rcfg++;
  end
  // random kicks, never more than six idle cycles apart, well inside the timeout
  always @(posedge mclk) begin
    #1;
    wdog_kick = kick_on && ((($random(seed) & 3) != 0) || kick_gap >= 6);
    kick_gap = wdog_kick ? 0 : kick_gap + 1;
  end
  task automatic mwait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // capture-ir loads 4'h1, shifted out lsb first
  task automatic ir(input logic [3:0] code);
    for (int i = 0; i < 4; i++) exp_q.push_back(i == 0);
    prog.shift_ir(code);
  endtask
  task automatic load_image();
    ir(4'h2);
    for (int k = 0; k < 16; k++) begin
      b = $random(seed);
      img[k*8+:8] = b;
      prog.shift_dr(b);
    end
  endtask
  task automatic run_init();
    // let config_done_flag settle and be read before init starts
    mwait(4);
    ir(4'h3);
    prog.idle(12);
    mwait(4);
  endtask
  initial begin
    #300000;
    err_count++;
    $display("[FAIL] run time expected finish seen hang");
    test_done();
  end
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    kick_on = 1'b0;
    seed = 56;
    err_count = 0;
    n_tests = 0;
    n_rcfg = 0;
    img = '0;
    fork
      mwait(8);
      prog.idle(4);
    join
    sys_rst = 1'b0;
    chk("flag pull", 1, config_done_flag_pin.oe);
    chk("icb", 8'h03, icb_applied);
    chk("ram", 0, config_ram);
    chk("init_done", 0, init_done);
    $display("test reset finished");
    prog.tap_reset();
    ir(4'hf);
    repeat (2) begin
      b = $random(seed);
      exp_q.push_back(1'b0);
      for (int i = 0; i < 7; i++) exp_q.push_back(b[i]);
      prog.shift_dr(b);
    end
    chk("tdo drained", 0, exp_q.size());
    $display("test bypass finished");
    load_image();
    mwait(4);
    chk("ram", img, config_ram);
    chk("flag pull", 0, config_done_flag_pin.oe);
    chk("icb", 8'h03, icb_applied);
    prog.shift_dr($random(seed));
    mwait(4);
    chk("ram", img, config_ram);
    chk("flag pull", 1, config_done_flag_pin.oe);
    run_init();
    chk("init_done", 0, init_done);
    $display("test image finished");
    load_image();
    ir(4'h6);
    prog.shift_dr(8'h00);
    run_init();
    chk("init_done", 1, init_done);
    chk("user_mode", 1, user_mode);
    chk("icb", 8'h02, icb_applied);
    mwait(40);
    chk("reconfig", 0, n_rcfg);
    $display("test default bits finished");
    kick_on = 1'b1;
    ir(4'h4);
    prog.shift_dr(8'h5b);
    load_image();
    run_init();
    chk("init_done", 1, init_done);
    chk("icb", 8'h5b, icb_applied);
    mwait(30);
    chk("reconfig", 0, n_rcfg);
    kick_on = 1'b0;
    mwait(25);
    chk("reconfig", 1, n_rcfg);
    prog.idle(6);
    mwait(4);
    chk("init_done", 0, init_done);
    chk("user_mode", 0, user_mode);
    chk("flag pull", 1, config_done_flag_pin.oe);
    chk("icb", 8'h5b, icb_applied);
    $display("test watchdog finished");
    chk("tdo drained", 0, exp_q.size());
    test_done();
  end
endmodule // tb_top
